// ### hdl/macrocell_pkg.sv
// Constants, types and helpers shared by the macrocell configuration block
package macrocell_pkg;

	// Array geometry
	localparam int CELL_COUNT    = 8;    // Output logic macrocells
	localparam int TERM_COUNT    = 8;    // Product terms per macrocell
	localparam int CENTRE_LO     = 3;    // Inner cell next to the centre
	localparam int CENTRE_HI     = 4;    // Other inner cell
	localparam int OUTER_LO      = 0;    // Outer cell that carries the clock pin
	localparam int OUTER_HI      = 7;    // Outer cell that carries the OE pin
	localparam int OE_TERM       = 0;    // Term reserved for the OE product

	// Register byte addresses on the bus
	localparam logic [31:0] MODE_ADDR   = 32'h0000_0000;
	localparam logic [31:0] CELL_ADDR   = 32'h0000_0004;
	localparam logic [31:0] STATUS_ADDR = 32'h0000_0008;
	localparam int          ADDR_WIDTH  = 4;

	// Field positions
	localparam int MODE_ARCH_BIT = 0;    // global_arch_select
	localparam int MODE_SYNC_BIT = 1;    // global_sync_select
	localparam int CELL_POL_LSB  = 0;    // Per-cell polarity bits 7:0
	localparam int CELL_IO_LSB   = 8;    // Per-cell cell_io_config bits 15:8
	localparam int STAT_Q_LSB    = 0;    // Macrocell register contents
	localparam int STAT_OE_LSB   = 8;    // Pin drive enables
	localparam int STAT_MODE_LSB = 16;   // Mode in force

	// Reset values: simple mode, active-high outputs, every cell an output
	localparam logic [1:0] MODE_RESET     = 2'h2;
	localparam logic [7:0] POL_RESET      = 8'h00;
	localparam logic [7:0] IO_RESET       = 8'h00;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Global mode, written as {sync, arch}
	typedef enum logic [1:0] {
		MODE_REG_ALT    = 2'b00,  // Unused code, behaves as registered
		MODE_REGISTERED = 2'b01,
		MODE_SIMPLE     = 2'b10,
		MODE_COMPLEX    = 2'b11
	} mode_e;

	typedef logic [CELL_COUNT-1:0] cell_vec_t;

	// Sum of all eight product terms
	function automatic logic sum_eight(input logic [TERM_COUNT-1:0] t);
		sum_eight = |t;
	endfunction

	// Sum of seven terms, leaving the OE term out
	function automatic logic sum_seven(input logic [TERM_COUNT-1:0] t);
		sum_seven = |t[TERM_COUNT-1:OE_TERM+1];
	endfunction

	// Outer neighbour whose pin a cell's column carries in simple mode;
	// the outer cells name themselves and carry nothing
	function automatic int adjacent(input int i);
		if (i < CENTRE_HI) begin
			adjacent = (i > OUTER_LO) ? i - 1 : i;
		end else begin
			adjacent = (i < OUTER_HI) ? i + 1 : i;
		end
	endfunction

endpackage

// ### hdl/macrocell_mode_config.sv
// Eight-cell output logic macrocell array with AXI4-Lite configuration
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module macrocell_mode_config (
	// Clock and reset
	input  wire logic                                      aclk,
	input  wire logic                                      aresetn,
	// AXI4-Lite write address
	input  wire logic [macrocell_pkg::ADDR_WIDTH-1:0]      s_axi_awaddr,
	input  wire logic                                      s_axi_awvalid,
	output logic                                           s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]                               s_axi_wdata,
	input  wire logic [3:0]                                s_axi_wstrb,
	input  wire logic                                      s_axi_wvalid,
	output logic                                           s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                                     s_axi_bresp,
	output logic                                           s_axi_bvalid,
	input  wire logic                                      s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [macrocell_pkg::ADDR_WIDTH-1:0]      s_axi_araddr,
	input  wire logic                                      s_axi_arvalid,
	output logic                                           s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]                                    s_axi_rdata,
	output logic [1:0]                                     s_axi_rresp,
	output logic                                           s_axi_rvalid,
	input  wire logic                                      s_axi_rready,
	// Special pins
	input  wire logic                                      clk_pin,
	input  wire logic                                      oe_pin_n,
	// Product terms from the AND array, one byte per cell
	input  wire logic [7:0][macrocell_pkg::TERM_COUNT-1:0] product_terms,
	// Macrocell pins
	input  wire macrocell_pkg::cell_vec_t                  pin_in,
	output macrocell_pkg::cell_vec_t                       pin_out,
	output macrocell_pkg::cell_vec_t                       pin_oe,
	// Columns back into the AND array
	output macrocell_pkg::cell_vec_t                       array_feedback,
	output logic [1:0]                                     array_special
);
	import macrocell_pkg::*;

	// Configuration and bus state
	mode_e                 mode, next_mode;           // Global mode
	cell_vec_t             polarity, next_polarity;   // Per-cell inversion
	cell_vec_t             io_config, next_io_config; // Per-cell I/O select
	logic                  aw_have, next_aw_have;     // Address captured
	logic                  w_have, next_w_have;       // Data captured
	logic [ADDR_WIDTH-1:0] wr_addr, next_wr_addr;     // Held write address
	logic [31:0]           wr_data, next_wr_data;     // Held write data
	logic [3:0]            wr_strb, next_wr_strb;     // Held byte enables
	logic                  next_awready, next_wready;
	logic                  next_bvalid, next_arready, next_rvalid;
	logic [1:0]            next_bresp, next_rresp;
	logic [31:0]           next_rdata;

	// Macrocell state
	cell_vec_t             cell_q, next_cell_q;       // Macrocell registers
	logic                  clk_pin_d;                 // Last clock pin level
	cell_vec_t             next_pin_out, next_pin_oe, next_feedback;
	logic [1:0]            next_special;
	logic                  clk_rise;                  // Clock pin rising
	cell_vec_t             cell_value;                // Polarised sums
	cell_vec_t             cell_reg;                  // Cell is a register

	// Byte-enable merge used by the configuration write
	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		merge = r;
	endfunction

	// Bus slave: write and read channels, register updates
	always_comb begin
		logic [31:0] cell_word;
		logic        do_write;
		cell_word      = 32'h0;
		do_write       = 1'b0;
		next_mode      = mode;
		next_polarity  = polarity;
		next_io_config = io_config;
		next_aw_have   = aw_have;
		next_w_have    = w_have;
		next_wr_addr   = wr_addr;
		next_wr_data   = wr_data;
		next_wr_strb   = wr_strb;
		next_bvalid    = s_axi_bvalid;
		next_bresp     = s_axi_bresp;
		next_rvalid    = s_axi_rvalid;
		next_rresp     = s_axi_rresp;
		next_rdata     = s_axi_rdata;
		// Response accepted by the master
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		// Address and data may arrive in either order
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_have = 1'b1;
			next_wr_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_have  = 1'b1;
			next_wr_data = s_axi_wdata;
			next_wr_strb = s_axi_wstrb;
		end
		// Both halves held: commit and answer
		if (aw_have && w_have && !s_axi_bvalid) begin
			do_write     = 1'b1;
			next_aw_have = 1'b0;
			next_w_have  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = RESP_OKAY;
		end
		if (do_write) begin
			case ({28'h0, wr_addr})
				MODE_ADDR: begin
					// Two global bits pick the mode for every cell
					if (wr_strb[0]) begin
						next_mode = mode_e'(wr_data[MODE_SYNC_BIT:MODE_ARCH_BIT]);
					end
				end
				CELL_ADDR: begin
					// Sixteen per-cell architecture bits
					cell_word      = merge({16'h0, io_config, polarity},
						wr_data, wr_strb);
					next_polarity  = cell_word[CELL_POL_LSB +: 8];
					next_io_config = cell_word[CELL_IO_LSB +: 8];
				end
				STATUS_ADDR: begin
					// Read-only, write ignored
				end
				default: begin
					next_bresp = RESP_SLVERR;
				end
			endcase
		end
		// Read channel
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp  = RESP_OKAY;
			case ({28'h0, s_axi_araddr})
				MODE_ADDR: begin
					next_rdata = {30'h0, mode};
				end
				CELL_ADDR: begin
					next_rdata = {16'h0, io_config, polarity};
				end
				STATUS_ADDR: begin
					next_rdata = {14'h0, mode, pin_oe, cell_q};
				end
				default: begin
					// Unmapped: zero data and an error
					next_rdata = 32'h0;
					next_rresp = RESP_SLVERR;
				end
			endcase
		end
		// Readies from flops: drop while a half or answer is held
		next_awready = !next_aw_have && !next_bvalid;
		next_wready  = !next_w_have && !next_bvalid;
		next_arready = !next_rvalid;
	end

	// Bus and configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode          <= mode_e'(MODE_RESET);
			polarity      <= POL_RESET;
			io_config     <= IO_RESET;
			aw_have       <= 1'b0;
			w_have        <= 1'b0;
			wr_addr       <= '0;
			wr_data       <= 32'h0;
			wr_strb       <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= RESP_OKAY;
			s_axi_rdata   <= 32'h0;
		end else begin
			mode          <= next_mode;
			polarity      <= next_polarity;
			io_config     <= next_io_config;
			aw_have       <= next_aw_have;
			w_have        <= next_w_have;
			wr_addr       <= next_wr_addr;
			wr_data       <= next_wr_data;
			wr_strb       <= next_wr_strb;
			s_axi_awready <= next_awready;
			s_axi_wready  <= next_wready;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rresp   <= next_rresp;
			s_axi_rdata   <= next_rdata;
		end
	end

	// Macrocell datapath: sums, polarity, drivers and feedback columns
	always_comb begin
		clk_rise      = clk_pin && !clk_pin_d;
		next_cell_q   = cell_q;
		next_pin_out  = '0;
		next_pin_oe   = '0;
		next_feedback = '0;
		next_special  = 2'b00;
		cell_value    = '0;
		cell_reg      = '0;
		for (int i = 0; i < CELL_COUNT; i++) begin
			case (mode)
				MODE_REGISTERED, MODE_REG_ALT: begin
					// Cleared config bit makes a register, set makes I/O
					cell_reg[i] = !io_config[i];
					// Register sums eight terms, I/O keeps one for OE
					if (cell_reg[i]) begin
						cell_value[i] = sum_eight(product_terms[i]) ^ polarity[i];
						// Shared clock pin loads every register
						if (clk_rise) begin
							next_cell_q[i] = cell_value[i];
						end
						next_pin_out[i]  = cell_q[i];
						next_pin_oe[i]   = !oe_pin_n;
						next_feedback[i] = cell_q[i];
					end else begin
						cell_value[i]    = sum_seven(product_terms[i]) ^ polarity[i];
						next_pin_out[i]  = cell_value[i];
						next_pin_oe[i]   = product_terms[i][OE_TERM];
						next_feedback[i] = pin_in[i];
					end
				end
				MODE_COMPLEX: begin
					// Combinational only, seven terms plus an OE term
					cell_value[i]   = sum_seven(product_terms[i]) ^ polarity[i];
					next_pin_out[i] = cell_value[i];
					next_pin_oe[i]  = product_terms[i][OE_TERM];
					// Outer columns are lent to the special pins
					if (i == OUTER_LO) begin
						next_feedback[i] = clk_pin;
					end else if (i == OUTER_HI) begin
						next_feedback[i] = !oe_pin_n;
					end else begin
						next_feedback[i] = pin_in[i];
					end
				end
				MODE_SIMPLE: begin
					// Eight terms, polarity per output
					cell_value[i]   = sum_eight(product_terms[i]) ^ polarity[i];
					next_pin_out[i] = cell_value[i];
					// Centre cells are always outputs; others may be inputs
					if (i == CENTRE_LO || i == CENTRE_HI) begin
						next_pin_oe[i] = 1'b1;
					end else begin
						next_pin_oe[i] = !io_config[i];
					end
					// Column carries the outer neighbour's pin, so no column
					// ever reads a centre pin; outer columns stay empty
					if (i != OUTER_LO && i != OUTER_HI) begin
						next_feedback[i] = pin_in[adjacent(i)];
					end
				end
				default: begin
					next_pin_oe[i] = 1'b0;
				end
			endcase
		end
		// Special pins become plain data outside registered mode
		if (mode == MODE_COMPLEX || mode == MODE_SIMPLE) begin
			next_special = {!oe_pin_n, clk_pin};
		end else begin
			// Reserved as clock and OE; never data
			next_special = 2'b00;
		end
	end

	// Macrocell and pin registers; pins lag the datapath by one cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cell_q         <= '0;
			clk_pin_d      <= 1'b0;
			pin_out        <= '0;
			pin_oe         <= '0;
			array_feedback <= '0;
			array_special  <= 2'b00;
		end else begin
			cell_q         <= next_cell_q;
			clk_pin_d      <= clk_pin;
			pin_out        <= next_pin_out;
			pin_oe         <= next_pin_oe;
			array_feedback <= next_feedback;
			array_special  <= next_special;
		end
	end

endmodule

`default_nettype wire

// ### sim/macrocell_checker.sv
// Port-level assertions of the macrocell block, with its bind
`timescale 1ns/1ps
`default_nettype none
module macrocell_checker
	import macrocell_pkg::*;
(
	// Clock, reset and write path
	input wire logic                         aclk,
	input wire logic                         aresetn,
	input wire logic [ADDR_WIDTH-1:0]        s_axi_awaddr,
	input wire logic                         s_axi_awvalid,
	input wire logic                         s_axi_awready,
	input wire logic [31:0]                  s_axi_wdata,
	input wire logic [3:0]                   s_axi_wstrb,
	input wire logic                         s_axi_wvalid,
	input wire logic                         s_axi_wready,
	input wire logic [1:0]                   s_axi_bresp,
	input wire logic                         s_axi_bvalid,
	input wire logic                         s_axi_bready,
	// Pins and array columns
	input wire logic                         clk_pin,
	input wire logic                         oe_pin_n,
	input wire logic [7:0][TERM_COUNT-1:0]   product_terms,
	input wire cell_vec_t                    pin_in,
	input wire cell_vec_t                    pin_out,
	input wire cell_vec_t                    pin_oe,
	input wire cell_vec_t                    array_feedback,
	input wire logic [1:0]                   array_special
);
	logic [3:0]  wa;      // Last write address taken
	logic [31:0] wd;      // Last write data taken
	logic [3:0]  ws;      // Last byte enables taken
	logic [1:0]  md;      // Shadow of the mode bits
	logic [7:0]  pol, io; // Shadow of the cell bits
	logic [1:0]  cnt;     // Cycles since the last write answer
	logic [7:0]  s8, s7, t0, pq;
	logic        cq, oq;
	logic        rg, sm, cx;
	// Judge only once a new setting has surely reached the pins
	assign rg = cnt == 2'h3 && !md[1];
	assign sm = cnt == 2'h3 && md == MODE_SIMPLE;
	assign cx = cnt == 2'h3 && md == MODE_COMPLEX;
	// Shadow the configuration and last cycle's inputs
	always_ff @(posedge aclk) begin
		if (s_axi_awvalid && s_axi_awready)
			wa <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready) begin
			wd <= s_axi_wdata;
			ws <= s_axi_wstrb;
		end
		for (int i = 0; i < 8; i++) begin
			s8[i] <= |product_terms[i];
			s7[i] <= |product_terms[i][7:1];
			t0[i] <= product_terms[i][0];
		end
		pq <= pin_in;
		cq <= clk_pin;
		oq <= oe_pin_n;
		if (!aresetn) begin
			{md, io, pol} <= {MODE_RESET, IO_RESET, POL_RESET};
			cnt <= 2'h0;
		end else begin
			if (s_axi_bvalid)
				cnt <= 2'h0;
			else if (cnt != 2'h3)
				cnt <= cnt + 2'h1;
			if (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY) begin
				if (wa == MODE_ADDR[3:0] && ws[0])
					md <= wd[1:0];
				if (wa == CELL_ADDR[3:0] && ws[0])
					pol <= wd[7:0];
				if (wa == CELL_ADDR[3:0] && ws[1])
					io <= wd[15:8];
			end
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_simple_oe: assert property (sm |-> pin_oe == ~(io & 8'he7))
		else $error("simple mode drive enables wrong");
	a_simple_out: assert property (
		sm |-> ((pin_out ^ s8 ^ pol) & pin_oe) == 8'h00)
		else $error("simple mode output value wrong");
	a_simple_fb: assert property (
		sm |-> array_feedback == {1'b0, pq[7:5], pq[2:0], 1'b0})
		else $error("simple mode feedback wrong");
	a_special_data: assert property (
		cnt == 2'h3 && md[1] |-> array_special == {!oq, cq})
		else $error("special pins not fed as data");
	a_special_held: assert property (rg |-> array_special == 2'h0)
		else $error("special pins leak into the array");
	a_complex_out: assert property (
		cx |-> ((pin_out ^ s7 ^ pol) & pin_oe) == 8'h00
		&& (pin_oe & 8'h7e) == (t0 & 8'h7e))
		else $error("complex mode output wrong");
	a_complex_fb: assert property (
		cx |-> array_feedback[0] == cq && array_feedback[7] == !oq)
		else $error("complex mode special feedback wrong");
	a_shared_oe: assert property (
		rg |-> (pin_oe & ~io) == ({8{!oq}} & ~io))
		else $error("shared enable not applied");
	a_reg_load: assert property (
		rg && !cq && clk_pin |=> ##1 ((pin_out ^ $past(s8) ^ pol) & ~io) == 8'h00)
		else $error("register load wrong");
	a_reg_hold: assert property (
		rg && !(!cq && clk_pin) |=> ##1 ((pin_out ^ $past(pin_out)) & ~io) == 8'h00)
		else $error("register changed without a clock rise");
	a_reg_comb: assert property (
		rg |-> ((pin_out ^ s7 ^ pol) & io & pin_oe) == 8'h00)
		else $error("registered mode I/O cell wrong");
	c_complex: cover property (cx);
	c_load: cover property (rg && !cq && clk_pin);
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule
bind macrocell_mode_config macrocell_checker chk_u (
	.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .clk_pin, .oe_pin_n, .product_terms,
	.pin_in, .pin_out, .pin_oe, .array_feedback, .array_special
);
`default_nettype wire

// ### sim/board_model.sv
// Board side of the macrocell pins: resolves each wire level
`timescale 1ns/1ps
`default_nettype none
module board_model (
	// Device side
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	// Board drive
	input wire logic [7:0] drv,
	output logic [7:0]     pin_in
);
	// Device wins where it drives; the board drives the rest
	always_comb
		for (int i = 0; i < 8; i++)
			pin_in[i] = pin_oe[i] ? pin_out[i] : drv[i];
endmodule
`default_nettype wire

// ### sim/macrocell_mode_config_tb.sv
// Self-checking bench for the macrocell mode block
`timescale 1ns/1ps
`default_nettype none
module macrocell_mode_config_tb;
	import macrocell_pkg::*;
	localparam logic [3:0] AM = MODE_ADDR[3:0];
	localparam logic [3:0] AC = CELL_ADDR[3:0];
	localparam logic [3:0] AS = STATUS_ADDR[3:0];
	// Bus side
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [3:0]  awa = 4'h0, ara = 4'h0;
	logic [3:0]  ws = 4'hf;
	logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic [31:0] wd = 32'h0, rd;
	logic        awr, wr, bv, arr, rv;
	logic [1:0]  bresp, rresp, sp;
	// Pin side
	logic        cp = 1'b0, oen = 1'b1;
	logic [63:0] pt = 64'h0;
	cell_vec_t   pin_i, pin_o, pin_e, fb;
	logic [7:0]  drv = 8'h81;
	int          err_total = 0, comparisons = 0, cyc = 0;
	macrocell_mode_config dut_u (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rr), .clk_pin(cp), .oe_pin_n(oen),
		.product_terms(pt), .pin_in(pin_i), .pin_out(pin_o),
		.pin_oe(pin_e), .array_feedback(fb), .array_special(sp));
	board_model brd_u (.pin_out(pin_o), .pin_oe(pin_e), .drv(drv),
		.pin_in(pin_i));
	initial
		forever #50 aclk = ~aclk;
	// Cut a hang short
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 2000) begin
			err_total++;
			wrap_up();
		end
	end
	task automatic check(input string n, input logic [31:0] s,
		input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	// Write: address and data offered together, each dropped when taken
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge aclk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do begin
			@(posedge aclk);
			if (awv && awr)
				awv <= 1'b0;
			if (wv && wr)
				wv <= 1'b0;
		end while (!(bv && br));
		br <= 1'b0;
		check("bresp", bresp, er);
	endtask
	task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do begin
			@(posedge aclk);
			if (arv && arr)
				arv <= 1'b0;
		end while (!(rv && rr));
		rr <= 1'b0;
		check("rdata", rd, ed);
		check("rresp", rresp, er);
	endtask
	// Drive the pins, then let feedback settle
	task automatic put(input logic [63:0] t, input logic c, input logic o);
		@(posedge aclk);
		pt <= t;
		cp <= c;
		oen <= o;
		repeat (3) @(posedge aclk);
		#1;
	endtask
	task automatic t_defaults();
		axi_rd(AM, {30'h0, MODE_RESET}, RESP_OKAY);
		axi_rd(AC, 32'h0, RESP_OKAY);
		axi_rd(4'hc, 32'h0, RESP_SLVERR);
		axi_wr(4'hc, 32'h3, RESP_SLVERR);
		axi_wr(AC, 32'hffff_ffff, RESP_OKAY);
		axi_wr(AS, 32'hffff_ffff, RESP_OKAY);
		axi_rd(AC, 32'h0000_ffff, RESP_OKAY);
		// Only the I/O byte enabled: polarity must survive
		ws <= 4'h2;
		axi_wr(AC, 32'h0000_5a00, RESP_OKAY);
		ws <= 4'hf;
		axi_rd(AC, 32'h0000_5aff, RESP_OKAY);
	endtask
	task automatic t_simple();
		axi_wr(AC, 32'h0000_9905, RESP_OKAY);
		put(64'h0000_ff00_0100_0080, 1'b1, 1'b0);
		check("oe", pin_e, 8'h7e);
		check("out", pin_o & pin_e, 8'h2c);
		check("fb", fb, 8'h5a);
		check("spec", sp, 2'h3);
	endtask
	task automatic t_complex();
		axi_wr(AM, 32'h3, RESP_OKAY);
		put(64'h0103_0201_0001_fe01, 1'b1, 1'b1);
		check("out", pin_o & 8'h54, 8'h44);
		check("oe", pin_e & 8'h7e, 8'h54);
		check("fb", fb & 8'h81, 8'h01);
		check("spec", sp, 2'h1);
	endtask
	task automatic t_registered();
		axi_wr(AC, 32'h0000_0f00, RESP_OKAY);
		axi_wr(AM, 32'h1, RESP_OKAY);
		put(64'h0101_0101_0101_0101, 1'b0, 1'b0);
		put(64'h0101_0101_0101_0101, 1'b1, 1'b0);
		check("q", pin_o, 8'hf0);
		check("oe", pin_e, 8'hff);
		check("spec", sp, 2'h0);
		put(64'h0, 1'b1, 1'b1);
		check("hold", pin_o & 8'hf0, 8'hf0);
		check("oe", pin_e, 8'h00);
		axi_rd(AS, 32'h0001_00f0, RESP_OKAY);
		put(64'h0, 1'b0, 1'b1);
		put(64'h0, 1'b1, 1'b1);
		axi_rd(AS, 32'h0001_0000, RESP_OKAY);
		axi_wr(AM, 32'h0, RESP_OKAY);
		put(64'h0, 1'b1, 1'b0);
		check("spec", sp, 2'h0);
		check("oe", pin_e & 8'hf0, 8'hf0);
	endtask
	task automatic wrap_up();
		$display("Mismatches %0d of %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_defaults();
		t_simple();
		t_complex();
		t_registered();
		wrap_up();
	end
endmodule
`default_nettype wire
